// *** core/dscp_code_select.sv ***
`timescale 1ns/10ps
module dscp_code_select (
	dscp_map_if.lookup lk // mapping table in, decoded priority out
);
	function automatic logic [dscp_map_pkg::NUM_CODES-1:0] decode_code(
		input logic [dscp_map_pkg::CODE_W-1:0] c
	);
		logic [dscp_map_pkg::NUM_CODES-1:0] v;
		v = '0;
		v[c] = 1'b1;
		return v;
	endfunction : decode_code

	logic [dscp_map_pkg::NUM_CODES-1:0] onehot;
	logic [dscp_map_pkg::PRIO_W-1:0] prio_acc;

	assign onehot = decode_code(lk.code); // RQ2
	assign lk.sel_onehot = onehot;

	// and-or select keeps the path flat instead of a 64-way mux tree
	always_comb begin
		prio_acc = '0;
		for (int i = 0; i < dscp_map_pkg::NUM_CODES; i++) begin
			if (onehot[i]) begin
				prio_acc = prio_acc | lk.map_bits[i*dscp_map_pkg::PRIO_W +: dscp_map_pkg::PRIO_W]; // RQ3
			end
		end
	end

	assign lk.prio = prio_acc;
endmodule : dscp_code_select

// *** core/dscp_map_if.sv ***
`timescale 1ns/10ps
interface dscp_map_if;
	logic [dscp_map_pkg::TABLE_W-1:0] map_bits;
	logic [dscp_map_pkg::CODE_W-1:0] code;
	logic [dscp_map_pkg::NUM_CODES-1:0] sel_onehot;
	logic [dscp_map_pkg::PRIO_W-1:0] prio;
	modport table_side (output map_bits, output code, input sel_onehot, input prio);
	modport lookup (input map_bits, input code, output sel_onehot, output prio);
endinterface : dscp_map_if

// *** core/dscp_map_pkg.sv ***
// Summary of operation
// [RQ1] priority comes from tos byte bits 7:2, for ipv4 and ipv6 alike
// [RQ2] the six-bit code is fully decoded into 64 selections, one field each
// [RQ3] frame priority equals the 2-bit field selected by the decoded code
// [RQ4] index 0x90 holds codes 0x00..0x03 in bits 1:0, 3:2, 5:4, 7:6
// [RQ5] each next index holds the next four codes, ascending from bits 1:0
// [RQ6] index 0x98 holds codes 0x20..0x23, code 0x20 in bits 1:0
// [RQ7] every field is read/write and resets to 00, so priority starts at zero
// [RQ8] indexes 0x99..0x9F continue the layout for codes 0x24..0x3F
// [RQ9] mapping applies only to ip frames; result is a 2-bit priority level
package dscp_map_pkg;
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned BYTE_SEL_W = 2;
	localparam int unsigned IDX_W = ADDR_W - BYTE_SEL_W;
	localparam int unsigned TOS_W = 8;
	localparam int unsigned CODE_LSB = 2;
	localparam int unsigned CODE_W = 6;
	localparam int unsigned NUM_CODES = 64;
	localparam int unsigned PRIO_W = 2;
	localparam int unsigned FIELDS_PER_REG = 4;
	localparam int unsigned FIELD_SEL_W = 2;
	localparam int unsigned MAP_REG_W = 8;
	localparam int unsigned NUM_MAP_REGS = 16;
	localparam int unsigned MAP_SEL_W = 4;
	localparam int unsigned TABLE_W = NUM_CODES * PRIO_W;
	localparam int unsigned CNT_W = 16;
	// register indexes; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_MAP_CODES_00_03 = 10'h090;
	localparam logic [IDX_W-1:0] IDX_MAP_CODES_04_07 = 10'h091;
	localparam logic [IDX_W-1:0] IDX_MAP_CODES_08_0B = 10'h092;
	localparam logic [IDX_W-1:0] IDX_MAP_CODES_0C_0F = 10'h093;
	localparam logic [IDX_W-1:0] IDX_MAP_CODES_10_13 = 10'h094;
	localparam logic [IDX_W-1:0] IDX_MAP_CODES_14_17 = 10'h095;
	localparam logic [IDX_W-1:0] IDX_MAP_CODES_18_1B = 10'h096;
	localparam logic [IDX_W-1:0] IDX_MAP_CODES_1C_1F = 10'h097;
	localparam logic [IDX_W-1:0] IDX_MAP_CODES_20_23 = 10'h098;
	localparam logic [IDX_W-1:0] IDX_MAP_CODES_3C_3F = 10'h09F;
	localparam logic [IDX_W-1:0] IDX_MAP_STATUS = 10'h0C0;
	localparam logic [IDX_W-1:0] IDX_FRAME_COUNTS = 10'h0C1;
	localparam logic [MAP_REG_W-1:0] MAP_RST = 8'h00;
	localparam logic [PRIO_W-1:0] PRIO_NON_IP = 2'h0;
	// status and count word layout
	localparam int unsigned ST_CODE_LSB = 0;
	localparam int unsigned ST_PRIO_LSB = 8;
	localparam int unsigned ST_IP_BIT = 12;
	localparam int unsigned CNT_NON_IP_LSB = 16;
endpackage : dscp_map_pkg

// *** core/dscp_priority_mapper.sv ***
`timescale 1ns/10ps
module dscp_priority_mapper (
	input wire logic pclk, // clock, 100 MHz
	input wire logic presetn, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction, 1 = write
	input wire logic [dscp_map_pkg::ADDR_W-1:0] paddr, // apb byte address
	input wire logic [dscp_map_pkg::DATA_W-1:0] pwdata, // apb write data
	input wire logic [3:0] pstrb, // apb write byte strobes
	output logic [dscp_map_pkg::DATA_W-1:0] prdata, // apb read data
	output logic pready, // apb ready, zero wait
	output logic pslverr, // apb error on unmapped address
	input wire logic hdr_valid, // parser presents a header this cycle
	input wire logic hdr_is_ip, // header is ipv4 or ipv6
	input wire logic [dscp_map_pkg::TOS_W-1:0] hdr_tos, // tos / traffic class byte
	output logic prio_valid, // priority valid, one-cycle pulse
	output logic [dscp_map_pkg::PRIO_W-1:0] prio, // frame priority level
	output logic prio_mapped // priority came from the table
);
	function automatic logic is_map_idx(input logic [dscp_map_pkg::IDX_W-1:0] idx);
		return (idx >= dscp_map_pkg::IDX_MAP_CODES_00_03) &&
			(idx <= dscp_map_pkg::IDX_MAP_CODES_3C_3F);
	endfunction : is_map_idx

	function automatic logic [dscp_map_pkg::PRIO_W-1:0] map_field(
		input logic [dscp_map_pkg::MAP_REG_W-1:0] r,
		input logic [dscp_map_pkg::FIELD_SEL_W-1:0] s
	);
		return r[s*dscp_map_pkg::PRIO_W +: dscp_map_pkg::PRIO_W];
	endfunction : map_field

	dscp_map_if u_if ();

	logic [dscp_map_pkg::MAP_REG_W-1:0] map_ff [dscp_map_pkg::NUM_MAP_REGS];
	logic [dscp_map_pkg::DATA_W-1:0] prdata_ff;
	logic prio_valid_ff;
	logic [dscp_map_pkg::PRIO_W-1:0] prio_ff;
	logic prio_mapped_ff;
	logic [dscp_map_pkg::CODE_W-1:0] last_code_ff;
	logic [dscp_map_pkg::CNT_W-1:0] ip_cnt_ff;
	logic [dscp_map_pkg::CNT_W-1:0] non_ip_cnt_ff;
	logic [dscp_map_pkg::CNT_W-1:0] nxt_ip_cnt;
	logic [dscp_map_pkg::CNT_W-1:0] nxt_non_ip_cnt;
	logic [dscp_map_pkg::PRIO_W-1:0] nxt_prio;

	// bus decode
	wire [dscp_map_pkg::IDX_W-1:0] reg_idx = paddr[dscp_map_pkg::ADDR_W-1:dscp_map_pkg::BYTE_SEL_W];
	wire [dscp_map_pkg::MAP_SEL_W-1:0] map_sel = reg_idx[dscp_map_pkg::MAP_SEL_W-1:0];
	wire aligned = (paddr[dscp_map_pkg::BYTE_SEL_W-1:0] == '0);
	wire setup_ph = psel && !penable;
	wire access_ph = psel && penable;
	wire map_hit = aligned && is_map_idx(reg_idx);
	wire status_hit = aligned && (reg_idx == dscp_map_pkg::IDX_MAP_STATUS);
	wire counts_hit = aligned && (reg_idx == dscp_map_pkg::IDX_FRAME_COUNTS);
	wire any_hit = map_hit || status_hit || counts_hit;
	// registers are one byte wide, so only lane 0 carries a write
	wire map_wr = access_ph && pwrite && map_hit && pstrb[0];

	wire [dscp_map_pkg::DATA_W-1:0] status_word =
		(dscp_map_pkg::DATA_W'(last_code_ff) << dscp_map_pkg::ST_CODE_LSB) |
		(dscp_map_pkg::DATA_W'(prio_ff) << dscp_map_pkg::ST_PRIO_LSB) |
		(dscp_map_pkg::DATA_W'(prio_mapped_ff) << dscp_map_pkg::ST_IP_BIT);
	wire [dscp_map_pkg::DATA_W-1:0] counts_word =
		(dscp_map_pkg::DATA_W'(non_ip_cnt_ff) << dscp_map_pkg::CNT_NON_IP_LSB) |
		dscp_map_pkg::DATA_W'(ip_cnt_ff);

	logic [dscp_map_pkg::DATA_W-1:0] rd_word;
	always_comb begin
		if (map_hit) begin
			rd_word = dscp_map_pkg::DATA_W'(map_ff[map_sel]); // RQ7
		end else if (status_hit) begin
			rd_word = status_word;
		end else if (counts_hit) begin
			rd_word = counts_word;
		end else begin
			rd_word = '0;
		end
	end

	assign pready = 1'b1;
	assign pslverr = access_ph && !any_hit;
	assign prdata = prdata_ff;

	// read data is captured in the setup phase so prdata comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= '0;
		end else if (setup_ph) begin
			prdata_ff <= pwrite ? '0 : rd_word;
		end
	end

	// mapping table: index low nibble picks the byte, fields ascend from bit 0
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < dscp_map_pkg::NUM_MAP_REGS; i++) begin
				map_ff[i] <= dscp_map_pkg::MAP_RST; // RQ7
			end
		end else if (map_wr) begin
			map_ff[map_sel] <= pwdata[dscp_map_pkg::MAP_REG_W-1:0]; // RQ4 RQ5 RQ6 RQ8
		end
	end

	// flatten the table: code n lives at bits 2n+1:2n
	for (genvar g = 0; g < dscp_map_pkg::NUM_MAP_REGS; g++) begin : g_flat
		assign u_if.map_bits[g*dscp_map_pkg::MAP_REG_W +: dscp_map_pkg::MAP_REG_W] = map_ff[g];
	end

	assign u_if.code = hdr_tos[dscp_map_pkg::TOS_W-1:dscp_map_pkg::CODE_LSB]; // RQ1

	dscp_code_select u_sel (
		.lk (u_if)
	);

	// non-ip frames bypass the table and take the fixed level
	assign nxt_prio = hdr_is_ip ? u_if.prio : dscp_map_pkg::PRIO_NON_IP; // RQ3 RQ9
	assign nxt_ip_cnt = ip_cnt_ff + dscp_map_pkg::CNT_W'(1);
	assign nxt_non_ip_cnt = non_ip_cnt_ff + dscp_map_pkg::CNT_W'(1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prio_valid_ff <= 1'b0;
			prio_ff <= dscp_map_pkg::PRIO_NON_IP;
			prio_mapped_ff <= 1'b0;
			last_code_ff <= '0;
		end else begin
			prio_valid_ff <= hdr_valid;
			if (hdr_valid) begin
				prio_ff <= nxt_prio; // RQ9
				prio_mapped_ff <= hdr_is_ip; // RQ9
				last_code_ff <= u_if.code;
			end
		end
	end

	// counters wrap; software takes differences between two reads
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ip_cnt_ff <= '0;
			non_ip_cnt_ff <= '0;
		end else if (hdr_valid && hdr_is_ip) begin
			ip_cnt_ff <= nxt_ip_cnt;
		end else if (hdr_valid) begin
			non_ip_cnt_ff <= nxt_non_ip_cnt;
		end
	end

	assign prio_valid = prio_valid_ff;
	assign prio = prio_ff;
	assign prio_mapped = prio_mapped_ff;

	// checks
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	logic post_rst_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			post_rst_ff <= 1'b1;
		end else begin
			post_rst_ff <= 1'b0;
		end
	end

	// independent reference: byte by tos[7:4], field by tos[3:2]
	wire [dscp_map_pkg::PRIO_W-1:0] ref_prio =
		map_field(map_ff[hdr_tos[dscp_map_pkg::TOS_W-1:dscp_map_pkg::TOS_W-dscp_map_pkg::MAP_SEL_W]],
			hdr_tos[dscp_map_pkg::CODE_LSB+dscp_map_pkg::FIELD_SEL_W-1:dscp_map_pkg::CODE_LSB]);

	AST_LOW_TOS_BITS_IGNORED: // RQ1
	assert property ($stable(hdr_tos[dscp_map_pkg::TOS_W-1:dscp_map_pkg::CODE_LSB]) &&
			$stable(u_if.map_bits) |-> $stable(u_if.prio))
		else $error("priority changed while only low tos bits moved");

	AST_ONEHOT_DECODE: // RQ2
	assert property ($onehot(u_if.sel_onehot) && u_if.sel_onehot[u_if.code])
		else $error("code decode is not a single matching selection");

	AST_PRIO_FROM_FIELD: // RQ3
	assert property (hdr_valid && hdr_is_ip |=> prio_valid && prio_mapped &&
			prio == $past(ref_prio))
		else $error("ip frame priority differs from the selected field");

	AST_IDX90_LAYOUT: // RQ4
	assert property (map_wr && reg_idx == dscp_map_pkg::IDX_MAP_CODES_00_03 |=>
			u_if.map_bits[dscp_map_pkg::MAP_REG_W-1:0] == $past(pwdata[dscp_map_pkg::MAP_REG_W-1:0]))
		else $error("write to first map register not seen at codes 0 to 3");

	AST_NEXT_REGS_LAYOUT: // RQ5
	assert property (map_wr && reg_idx > dscp_map_pkg::IDX_MAP_CODES_00_03 &&
			reg_idx < dscp_map_pkg::IDX_MAP_CODES_20_23 |=>
			map_ff[$past(map_sel)] == $past(pwdata[dscp_map_pkg::MAP_REG_W-1:0]) &&
			u_if.map_bits[$past(map_sel)*dscp_map_pkg::MAP_REG_W +: dscp_map_pkg::MAP_REG_W]
			== $past(pwdata[dscp_map_pkg::MAP_REG_W-1:0]))
		else $error("map register write landed at the wrong codes");

	AST_IDX98_LAYOUT: // RQ6
	assert property (map_wr && reg_idx == dscp_map_pkg::IDX_MAP_CODES_20_23 |=>
			u_if.map_bits[71:64] == $past(pwdata[dscp_map_pkg::MAP_REG_W-1:0]))
		else $error("write to codes 0x20 to 0x23 not seen at bits 71:64");

	AST_RESET_ZERO: // RQ7
	assert property (post_rst_ff |-> u_if.map_bits == '0 && prio == dscp_map_pkg::PRIO_NON_IP)
		else $error("mapping table not cleared by reset");

	AST_READBACK: // RQ7
	assert property (setup_ph && !pwrite && map_hit ##1 access_ph |->
			prdata == dscp_map_pkg::DATA_W'($past(map_ff[map_sel])))
		else $error("map register read returned wrong data");

	AST_UPPER_REGS_LAYOUT: // RQ8
	assert property (map_wr && reg_idx == dscp_map_pkg::IDX_MAP_CODES_3C_3F |=>
			u_if.map_bits[127:120] == $past(pwdata[dscp_map_pkg::MAP_REG_W-1:0]))
		else $error("write to codes 0x3C to 0x3F not seen at top bits");

	AST_NON_IP_FIXED: // RQ9
	assert property (hdr_valid && !hdr_is_ip |=> prio_valid && !prio_mapped &&
			prio == dscp_map_pkg::PRIO_NON_IP)
		else $error("non-ip frame was mapped");

	AST_PRIO_HOLDS: // RQ9
	assert property (!hdr_valid |=> !prio_valid && $stable(prio) && $stable(prio_mapped))
		else $error("priority changed without a header");

	AST_UNMAPPED_ERR:
	assert property (access_ph && !any_hit |-> pslverr ##1 $stable(u_if.map_bits))
		else $error("unmapped access not flagged or altered the table");

	AST_IDX91_LAYOUT: // RQ5
	assert property (map_wr && map_sel == 4'h1 |=>
			u_if.map_bits[15:8] == $past(pwdata[dscp_map_pkg::MAP_REG_W-1:0]))
		else $error("write to codes 0x04 to 0x07 not seen at bits 15:8");

	AST_IDX92_LAYOUT: // RQ5
	assert property (map_wr && map_sel == 4'h2 |=>
			u_if.map_bits[23:16] == $past(pwdata[dscp_map_pkg::MAP_REG_W-1:0]))
		else $error("write to codes 0x08 to 0x0B not seen at bits 23:16");

	AST_IDX93_LAYOUT: // RQ5
	assert property (map_wr && map_sel == 4'h3 |=>
			u_if.map_bits[31:24] == $past(pwdata[dscp_map_pkg::MAP_REG_W-1:0]))
		else $error("write to codes 0x0C to 0x0F not seen at bits 31:24");

	AST_IDX94_LAYOUT: // RQ5
	assert property (map_wr && map_sel == 4'h4 |=>
			u_if.map_bits[39:32] == $past(pwdata[dscp_map_pkg::MAP_REG_W-1:0]))
		else $error("write to codes 0x10 to 0x13 not seen at bits 39:32");

	AST_IDX95_LAYOUT: // RQ5
	assert property (map_wr && map_sel == 4'h5 |=>
			u_if.map_bits[47:40] == $past(pwdata[dscp_map_pkg::MAP_REG_W-1:0]))
		else $error("write to codes 0x14 to 0x17 not seen at bits 47:40");

	AST_IDX96_LAYOUT: // RQ5
	assert property (map_wr && map_sel == 4'h6 |=>
			u_if.map_bits[55:48] == $past(pwdata[dscp_map_pkg::MAP_REG_W-1:0]))
		else $error("write to codes 0x18 to 0x1B not seen at bits 55:48");

	AST_IDX97_LAYOUT: // RQ5
	assert property (map_wr && map_sel == 4'h7 |=>
			u_if.map_bits[63:56] == $past(pwdata[dscp_map_pkg::MAP_REG_W-1:0]))
		else $error("write to codes 0x1C to 0x1F not seen at bits 63:56");

	AST_IDX99_LAYOUT: // RQ8
	assert property (map_wr && map_sel == 4'h9 |=>
			u_if.map_bits[79:72] == $past(pwdata[dscp_map_pkg::MAP_REG_W-1:0]))
		else $error("write to codes 0x24 to 0x27 not seen at bits 79:72");

	AST_IDX9A_LAYOUT: // RQ8
	assert property (map_wr && map_sel == 4'hA |=>
			u_if.map_bits[87:80] == $past(pwdata[dscp_map_pkg::MAP_REG_W-1:0]))
		else $error("write to codes 0x28 to 0x2B not seen at bits 87:80");

	AST_IDX9B_LAYOUT: // RQ8
	assert property (map_wr && map_sel == 4'hB |=>
			u_if.map_bits[95:88] == $past(pwdata[dscp_map_pkg::MAP_REG_W-1:0]))
		else $error("write to codes 0x2C to 0x2F not seen at bits 95:88");

	AST_IDX9C_LAYOUT: // RQ8
	assert property (map_wr && map_sel == 4'hC |=>
			u_if.map_bits[103:96] == $past(pwdata[dscp_map_pkg::MAP_REG_W-1:0]))
		else $error("write to codes 0x30 to 0x33 not seen at bits 103:96");

	AST_IDX9D_LAYOUT: // RQ8
	assert property (map_wr && map_sel == 4'hD |=>
			u_if.map_bits[111:104] == $past(pwdata[dscp_map_pkg::MAP_REG_W-1:0]))
		else $error("write to codes 0x34 to 0x37 not seen at bits 111:104");

	AST_IDX9E_LAYOUT: // RQ8
	assert property (map_wr && map_sel == 4'hE |=>
			u_if.map_bits[119:112] == $past(pwdata[dscp_map_pkg::MAP_REG_W-1:0]))
		else $error("write to codes 0x38 to 0x3B not seen at bits 119:112");

	AST_STRB_OFF_NO_WRITE: // RQ7
	assert property (access_ph && pwrite && !pstrb[0] |=> $stable(u_if.map_bits))
		else $error("write without lane 0 strobe altered the table");

	AST_MISALIGNED_ERR: // RQ7
	assert property (access_ph && !aligned |-> pslverr ##1 $stable(u_if.map_bits))
		else $error("misaligned access not flagged or altered the table");

	AST_READ_NO_WRITE: // RQ7
	assert property (access_ph && !pwrite |=> $stable(u_if.map_bits))
		else $error("read access altered the table");

	AST_MAP_READ_UPPER_ZERO: // RQ7
	assert property (access_ph && !pwrite && map_hit |-> prdata[31:8] == '0)
		else $error("map register read shows upper bits set");

	AST_WRITE_PRDATA_ZERO:
	assert property (access_ph && pwrite |-> prdata == '0)
		else $error("read data not cleared during a write");

	AST_IP_COUNT: // RQ9
	assert property (hdr_valid && hdr_is_ip |=>
			ip_cnt_ff == $past(ip_cnt_ff) + dscp_map_pkg::CNT_W'(1) && $stable(non_ip_cnt_ff))
		else $error("ip header count did not advance by one");

	AST_NON_IP_COUNT: // RQ9
	assert property (hdr_valid && !hdr_is_ip |=>
			non_ip_cnt_ff == $past(non_ip_cnt_ff) + dscp_map_pkg::CNT_W'(1) && $stable(ip_cnt_ff))
		else $error("non-ip header count did not advance by one");

	AST_LAST_CODE: // RQ1
	assert property (hdr_valid |=>
			last_code_ff == $past(hdr_tos[dscp_map_pkg::TOS_W-1:dscp_map_pkg::CODE_LSB]))
		else $error("status code is not bits 7:2 of the last header");

	AST_STATUS_READ:
	assert property (setup_ph && !pwrite && status_hit ##1 access_ph |->
			prdata[dscp_map_pkg::CODE_W-1:0] == $past(last_code_ff))
		else $error("status read returned wrong code");
endmodule : dscp_priority_mapper

// *** tb/dscp_hdr_partner.sv ***
`timescale 1ns/10ps
// parser and queue manager stand-in: one header per send, captures the answer
module dscp_hdr_partner (
	input wire logic pclk, // clock
	input wire logic presetn, // async reset, active low
	input wire logic send, // present one header next cycle
	input wire logic send_ip, // header kind for that header
	input wire logic [7:0] send_tos, // tos byte for that header
	output logic hdr_valid, // header strobe to the mapper
	output logic hdr_is_ip, // ip header flag
	output logic [7:0] hdr_tos, // tos byte
	input wire logic prio_valid, // answer strobe
	input wire logic [1:0] prio, // answer level
	input wire logic prio_mapped, // answer came from table
	output logic seen_ff, // an answer was captured
	output logic [1:0] seen_prio_ff, // captured level
	output logic seen_mapped_ff // captured table flag
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hdr_valid <= 1'h0;
			hdr_is_ip <= 1'h0;
			hdr_tos <= 8'h00;
		end else if (send) begin
			hdr_valid <= 1'h1;
			hdr_is_ip <= send_ip;
			hdr_tos <= send_tos;
		end else begin
			// qualifiers are junk between headers so a stale sample cannot pass
			hdr_valid <= 1'h0;
			hdr_is_ip <= ~hdr_is_ip;
			hdr_tos <= ~hdr_tos;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seen_ff <= 1'h0;
			seen_prio_ff <= 2'h0;
			seen_mapped_ff <= 1'h0;
		end else begin
			seen_ff <= prio_valid;
			if (prio_valid) begin
				seen_prio_ff <= prio;
				seen_mapped_ff <= prio_mapped;
			end
		end
	end
endmodule : dscp_hdr_partner

// *** tb/tb_dscp_priority_mapper.sv ***
`timescale 1ns/10ps
module tb_dscp_priority_mapper;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, send, send_ip;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic [7:0] send_tos, hdr_tos;
	logic hdr_valid, hdr_is_ip, prio_valid, prio_mapped, seen, seen_mapped, err;
	logic [1:0] prio, seen_prio;
	logic [7:0] shadow [16];
	int miscompares = 0;
	int tests_run = 0;
	int n_ip = 0;
	int n_non = 0;
	dscp_priority_mapper dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .hdr_valid(hdr_valid), .hdr_is_ip(hdr_is_ip),
		.hdr_tos(hdr_tos), .prio_valid(prio_valid), .prio(prio), .prio_mapped(prio_mapped));
	dscp_hdr_partner far (.pclk(pclk), .presetn(presetn), .send(send), .send_ip(send_ip),
		.send_tos(send_tos), .hdr_valid(hdr_valid), .hdr_is_ip(hdr_is_ip), .hdr_tos(hdr_tos),
		.prio_valid(prio_valid), .prio(prio), .prio_mapped(prio_mapped), .seen_ff(seen),
		.seen_prio_ff(seen_prio), .seen_mapped_ff(seen_mapped));
	initial begin
		pclk = 1'h0;
		forever #5 pclk = ~pclk;
	end
	task automatic print_verdict;
		$display("checks %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : print_verdict
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
		input logic [3:0] st);
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= wr;
		paddr <= {idx, 2'h0};
		pwdata <= wd;
		pstrb <= st;
		@(posedge pclk);
		penable <= 1'h1;
		do
			@(posedge pclk);
		while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	// code n sits in index 0x90 + n/4, bits 2*(n%4) upward
	function automatic logic [1:0] exp_prio(input logic ip, input logic [7:0] tos);
		logic [7:0] r;
		r = shadow[tos[7:4]];
		exp_prio = ip ? r[2*tos[3:2] +: 2] : 2'h0;
	endfunction : exp_prio
	task automatic hdr(input logic ip, input logic [7:0] tos);
		if (ip)
			n_ip++;
		else
			n_non++;
		@(posedge pclk);
		send <= 1'h1;
		send_ip <= ip;
		send_tos <= tos;
		@(posedge pclk);
		send <= 1'h0;
		for (int n = 0; n < 8 && seen !== 1'h1; n++)
			@(posedge pclk) #1;
		cmp({29'h0, seen, seen_prio}, {30'h1, exp_prio(ip, tos)});
		cmp({31'h0, seen_mapped}, {31'h0, ip});
	endtask : hdr
	task automatic check_regs;
		for (int i = 0; i < 16; i++) begin
			apb(1'h0, 10'h090 + i[9:0], 32'h0, 4'h0);
			cmp(rd, {24'h0, shadow[i]});
		end
	endtask : check_regs
	initial begin
		repeat (20000) @(posedge pclk);
		miscompares++;
		print_verdict();
	end
	initial begin
		{psel, penable, pwrite, send, send_ip} = 5'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'h0;
		send_tos = 8'h00;
		foreach (shadow[i])
			shadow[i] = 8'h00;
		presetn = 1'h0;
		void'($urandom(13529));
		repeat (16) @(posedge pclk);
		presetn <= 1'h1;
		check_regs();
		hdr(1'h1, 8'hFF);
		// every code once with random low tos bits and random table
		for (int i = 0; i < 16; i++) begin
			shadow[i] = 8'($urandom);
			apb(1'h1, 10'h090 + i[9:0], {24'($urandom), shadow[i]}, 4'h1);
		end
		check_regs();
		for (int c = 0; c < 64; c++)
			hdr(1'h1, {c[5:0], 2'($urandom)});
		for (int k = 0; k < 8; k++)
			hdr(1'($urandom), 8'($urandom));
		// strobe off: write must be dropped
		apb(1'h1, 10'h098, 32'h0000_00FF, 4'h0);
		check_regs();
		apb(1'h0, 10'h0A0, 32'h0, 4'h0);
		cmp(rd, 32'h0);
		cmp({31'h0, err}, {31'h0, 1'h1});
		shadow[8] = 8'hC0;
		apb(1'h1, 10'h098, 32'h0000_00C0, 4'h1);
		hdr(1'h1, 8'h8C);
		hdr(1'h0, 8'h8C);
		// status shows the last header: code 0x23, fixed level, not mapped
		apb(1'h0, 10'h0C0, 32'h0, 4'h0);
		cmp(rd, 32'h0000_0023);
		apb(1'h0, 10'h0C1, 32'h0, 4'h0);
		cmp(rd, {16'(n_non), 16'(n_ip)});
		print_verdict();
	end
endmodule : tb_dscp_priority_mapper
